/* core/cnm_pkg.sv */
// constants, field layouts and types of the carrier oscillator and mixer
// ==========================================================================
package cnm_pkg;

  // ========================================================================
  // control word indices on the processor write port
  localparam logic [4:0] CW_CTRL0 = 5'h00;
  localparam logic [4:0] CW_CTRL1 = 5'h01;
  localparam logic [4:0] CW_CENTER = 5'h03;
  localparam logic [4:0] CW_PHASE = 5'h04;
  localparam logic [4:0] CW_XFER_FREQ = 5'h05;
  localparam logic [4:0] CW_XFER_PHASE = 5'h06;
  localparam logic [4:0] CW_RESAMP = 5'h0B;

  // ========================================================================
  // field positions
  localparam int CTRL0_ACC_CLR_BIT = 0;
  localparam int CTRL0_OFS_ZERO_BIT = 1;
  localparam int CTRL0_WIDTH_LSB = 4;
  localparam int CTRL1_SYNC_EN_BIT = 20;
  localparam int RESAMP_WIDTH_LSB = 3;
  localparam int PHASE_LSB = 0;

  // ========================================================================
  // widths and reset values
  localparam int FREQ_W = 32;
  localparam int PHASE_W = 10;
  localparam int LUT_ADDR_W = 18;
  localparam int AMP_W = 18;
  localparam int SAMPLE_W = 14;
  localparam int MIX_W = 15;
  localparam int CNT_W = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;

  // ========================================================================
  // one mixer result, I and Q together
  typedef struct packed {
    logic [MIX_W-1:0] i;
    logic [MIX_W-1:0] q;
  } cnm_iq_t;

  // serial word length in bits from its two-bit select
  function automatic logic [CNT_W-1:0] widthBits(input logic [1:0] sel);
    widthBits = {1'b0, sel, 3'h0} + 6'h08;
  endfunction

endpackage

/* core/cnm_serial_offset.sv */
// two-pin serial offset word loader with 32-bit holding register
`timescale 1ns/1ps
module cnm_serial_offset (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serialBit,
  input wire logic wordStrobe,
  input wire logic [1:0] widthSel,
  output logic [cnm_pkg::FREQ_W-1:0] holdWord,
  output logic loadPulse
);

  logic [cnm_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [cnm_pkg::CNT_W-1:0] wLat_ff, nxt_wLat;
  logic [cnm_pkg::FREQ_W-1:0] shift_ff, nxt_shift;
  logic [cnm_pkg::FREQ_W-1:0] nxt_holdWord;
  logic nxt_loadPulse;

  // ========================================================================
  // shift and count
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_wLat = wLat_ff;
    nxt_shift = shift_ff;
    nxt_holdWord = holdWord;
    nxt_loadPulse = 1'b0;
    if (cnt_ff != cnm_pkg::CNT_RESET) begin
      nxt_shift = {shift_ff[cnm_pkg::FREQ_W-2:0], serialBit};
      nxt_cnt = cnt_ff - 6'h01;
      if (cnt_ff == 6'h01) begin
        nxt_holdWord = nxt_shift << (6'h20 - wLat_ff);
        nxt_loadPulse = 1'b1;
      end
    end
    // strobe may share the last bit's cycle, so it is handled last
    if (wordStrobe) begin
      nxt_cnt = cnm_pkg::widthBits(widthSel);
      nxt_wLat = nxt_cnt;
      nxt_shift = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_ff <= cnm_pkg::CNT_RESET;
      wLat_ff <= cnm_pkg::CNT_RESET;
      shift_ff <= '0;
      holdWord <= '0;
      loadPulse <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      wLat_ff <= nxt_wLat;
      shift_ff <= nxt_shift;
      holdWord <= nxt_holdWord;
      loadPulse <= nxt_loadPulse;
    end
  end

  // ========================================================================
  // checks
  a_count_eight: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wordStrobe && widthSel == 2'h0 ##1 (!wordStrobe)[*7] |=> ##1 loadPulse)
    else $error("8-bit word did not load after eight bits");
  a_short_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    loadPulse && wLat_ff == 6'h08 |-> holdWord[23:0] == 24'h000000)
    else $error("short word left low bits set");

endmodule

/* core/cnm_top.sv */
// carrier oscillator, sine/cosine lookup, quadrature mixer and output buffer
`timescale 1ns/1ps
module cnm_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cpuWrStrobe,
  input wire logic [4:0] cpuAddr,
  input wire logic [31:0] cpuWrData,
  output logic [31:0] cpuRdData,
  input wire logic input_sample_enable_n,
  input wire logic [cnm_pkg::SAMPLE_W-1:0] sampleIn,
  input wire logic front_end_sync_in,
  input wire logic carrier_offset_serial_data,
  input wire logic carrier_offset_word_strobe,
  input wire logic resampler_offset_serial_data,
  input wire logic resampler_offset_word_strobe,
  output logic sampleReady,
  output logic outValid,
  output cnm_pkg::cnm_iq_t outIq,
  input wire logic outReady,
  output logic [cnm_pkg::FREQ_W-1:0] resamplerOffsetHold,
  output logic resamplerOffsetLoad
);

  // ========================================================================
  // pin synchronisers: enable, sample, sync, two serial ports
  localparam int PIN_W = cnm_pkg::SAMPLE_W + 6;
  logic [PIN_W-1:0] pinMeta_ff, pinSync_ff;
  logic syncPrev_ff;
  logic enSyncN, syncPin, cofBit, cofStrobe, sofBit, sofStrobe;
  logic [cnm_pkg::SAMPLE_W-1:0] sampleSync;

  // first stage is read only by the second
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinMeta_ff <= {1'b1, {(PIN_W-1){1'b0}}};
      pinSync_ff <= {1'b1, {(PIN_W-1){1'b0}}};
      syncPrev_ff <= 1'b0;
    end else begin
      pinMeta_ff <= {input_sample_enable_n, front_end_sync_in,
                     carrier_offset_serial_data, carrier_offset_word_strobe,
                     resampler_offset_serial_data, resampler_offset_word_strobe, sampleIn};
      pinSync_ff <= pinMeta_ff;
      syncPrev_ff <= pinSync_ff[PIN_W-2];
    end
  end

  assign {enSyncN, syncPin, cofBit, cofStrobe, sofBit, sofStrobe, sampleSync} = pinSync_ff;

  // ========================================================================
  // control words, holding and active registers
  logic [31:0] ctrl0_ff, nxt_ctrl0, ctrl1_ff, nxt_ctrl1, resamp_ff, nxt_resamp;
  logic [cnm_pkg::FREQ_W-1:0] freqHold_ff, nxt_freqHold, freqAct_ff, nxt_freqAct;
  logic [cnm_pkg::PHASE_W-1:0] phaseHold_ff, nxt_phaseHold, phaseAct_ff, nxt_phaseAct;
  logic [31:0] nxt_cpuRdData;
  logic syncEdge, wrFreqXfer, wrPhaseXfer, anyXfer;

  assign syncEdge = pinSync_ff[PIN_W-2] && !syncPrev_ff;
  assign wrFreqXfer = cpuWrStrobe && cpuAddr == cnm_pkg::CW_XFER_FREQ;
  assign wrPhaseXfer = cpuWrStrobe && cpuAddr == cnm_pkg::CW_XFER_PHASE;
  assign anyXfer = wrFreqXfer || wrPhaseXfer
                   || (syncEdge && ctrl1_ff[cnm_pkg::CTRL1_SYNC_EN_BIT]);

  // writes land in holding words; active words change only on a transfer
  always_comb begin
    nxt_ctrl0 = ctrl0_ff;
    nxt_ctrl1 = ctrl1_ff;
    nxt_resamp = resamp_ff;
    nxt_freqHold = freqHold_ff;
    nxt_phaseHold = phaseHold_ff;
    nxt_freqAct = freqAct_ff;
    nxt_phaseAct = phaseAct_ff;
    if (cpuWrStrobe) begin
      case (cpuAddr)
        cnm_pkg::CW_CTRL0: nxt_ctrl0 = cpuWrData;
        cnm_pkg::CW_CTRL1: nxt_ctrl1 = cpuWrData;
        cnm_pkg::CW_RESAMP: nxt_resamp = cpuWrData;
        cnm_pkg::CW_CENTER: nxt_freqHold = cpuWrData;
        cnm_pkg::CW_PHASE: nxt_phaseHold = cpuWrData[cnm_pkg::PHASE_LSB +: cnm_pkg::PHASE_W];
        default: nxt_ctrl0 = ctrl0_ff;
      endcase
    end
    if (wrFreqXfer) begin
      nxt_freqAct = freqHold_ff;
    end
    if (wrPhaseXfer) begin
      nxt_phaseAct = phaseHold_ff;
    end
    if (syncEdge && ctrl1_ff[cnm_pkg::CTRL1_SYNC_EN_BIT]) begin
      nxt_freqAct = freqHold_ff;
      nxt_phaseAct = phaseHold_ff;
    end
    // read-back shows the active words, which software cannot write directly
    case (cpuAddr)
      cnm_pkg::CW_CTRL0: nxt_cpuRdData = ctrl0_ff;
      cnm_pkg::CW_CTRL1: nxt_cpuRdData = ctrl1_ff;
      cnm_pkg::CW_CENTER: nxt_cpuRdData = freqAct_ff;
      cnm_pkg::CW_PHASE: nxt_cpuRdData = {22'h000000, phaseAct_ff};
      cnm_pkg::CW_RESAMP: nxt_cpuRdData = resamp_ff;
      default: nxt_cpuRdData = 32'h0000_0000;
    endcase
  end

  // no transfer before a strobe or sync
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl0_ff <= cnm_pkg::CTRL_RESET;
      ctrl1_ff <= cnm_pkg::CTRL_RESET;
      resamp_ff <= cnm_pkg::CTRL_RESET;
      freqHold_ff <= '0;
      phaseHold_ff <= '0;
      freqAct_ff <= '0;
      phaseAct_ff <= '0;
      cpuRdData <= 32'h0000_0000;
    end else begin
      ctrl0_ff <= nxt_ctrl0;
      ctrl1_ff <= nxt_ctrl1;
      resamp_ff <= nxt_resamp;
      freqHold_ff <= nxt_freqHold;
      phaseHold_ff <= nxt_phaseHold;
      freqAct_ff <= nxt_freqAct;
      phaseAct_ff <= nxt_phaseAct;
      cpuRdData <= nxt_cpuRdData;
    end
  end

  // ========================================================================
  // serial offset ports
  logic [cnm_pkg::FREQ_W-1:0] carrierOfsHold;

  cnm_serial_offset u_carrierOfs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .serialBit(cofBit),
    .wordStrobe(cofStrobe),
    .widthSel(ctrl0_ff[cnm_pkg::CTRL0_WIDTH_LSB +: 2]),
    .holdWord(carrierOfsHold),
    .loadPulse()
  );

  cnm_serial_offset u_resamplerOfs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .serialBit(sofBit),
    .wordStrobe(sofStrobe),
    .widthSel(resamp_ff[cnm_pkg::RESAMP_WIDTH_LSB +: 2]),
    .holdWord(resamplerOffsetHold),
    .loadPulse(resamplerOffsetLoad)
  );

  // ========================================================================
  // oscillator and mixer pipeline
  logic [cnm_pkg::FREQ_W-1:0] acc_ff, nxt_acc, freqWord;
  logic s1Valid_ff, nxt_s1Valid, resValid_ff, nxt_resValid;
  logic [cnm_pkg::SAMPLE_W-1:0] s1Sample_ff, nxt_s1Sample;
  logic [cnm_pkg::LUT_ADDR_W-1:0] s1Addr_ff, nxt_s1Addr;
  logic [cnm_pkg::PHASE_W-1:0] phaseTop;
  cnm_pkg::cnm_iq_t res_ff, nxt_res;
  logic pipeMove, take, nxt_sampleReady;
  logic tailValid_ff, nxt_tailValid, nxt_outValid;
  cnm_pkg::cnm_iq_t tail_ff, nxt_tail, nxt_outIq;

  // quarter-wave amplitude, k in 0..16 of a quarter cycle; coarse 16-step
  // table traded against the size of a full 18-bit address ROM
  function automatic logic [cnm_pkg::AMP_W-1:0] quarterAmp(input logic [4:0] k);
    case (k)
      5'h00: quarterAmp = 18'h00000;
      5'h01: quarterAmp = 18'h0322F;
      5'h02: quarterAmp = 18'h063E3;
      5'h03: quarterAmp = 18'h094A0;
      5'h04: quarterAmp = 18'h0C3EF;
      5'h05: quarterAmp = 18'h0F15B;
      5'h06: quarterAmp = 18'h11C74;
      5'h07: quarterAmp = 18'h144CF;
      5'h08: quarterAmp = 18'h16A09;
      5'h09: quarterAmp = 18'h18BC8;
      5'h0A: quarterAmp = 18'h1A9B6;
      5'h0B: quarterAmp = 18'h1C38B;
      5'h0C: quarterAmp = 18'h1D907;
      5'h0D: quarterAmp = 18'h1E9F4;
      5'h0E: quarterAmp = 18'h1F629;
      5'h0F: quarterAmp = 18'h1FD88;
      default: quarterAmp = 18'h1FFFF;
    endcase
  endfunction

  // signed sine of an 18-bit phase, folded from the quarter table
  function automatic logic signed [cnm_pkg::AMP_W-1:0] sinAmp(input logic [17:0] ph);
    logic [4:0] idx;
    logic [cnm_pkg::AMP_W-1:0] mag;
    idx = {1'b0, ph[15:12]};
    mag = ph[16] ? quarterAmp(5'h10 - idx) : quarterAmp(idx);
    sinAmp = ph[17] ? -$signed(mag) : $signed(mag);
  endfunction

  // round half away from zero, keep 15 bits, clamp the one overflow case
  function automatic logic [cnm_pkg::MIX_W-1:0] roundMix(input logic signed [31:0] p);
    logic signed [31:0] r;
    r = p[31] ? p + 32'sh0000_7FFF : p + 32'sh0000_8000;
    roundMix = (r[31:16] == 16'h4000) ? 15'h3FFF : r[30:16];
  endfunction

  // advance only when the result stage can drain into the buffer
  assign pipeMove = !resValid_ff || !tailValid_ff;
  assign take = pipeMove && !enSyncN;
  // wraps modulo 2^32; read as signed
  assign freqWord = freqAct_ff
                    + (ctrl0_ff[cnm_pkg::CTRL0_OFS_ZERO_BIT] ? '0 : carrierOfsHold);
  // offset added to top bits, wraps
  assign phaseTop = acc_ff[31:22] + phaseAct_ff;

  always_comb begin
    nxt_acc = acc_ff;
    nxt_s1Valid = s1Valid_ff;
    nxt_s1Sample = s1Sample_ff;
    nxt_s1Addr = s1Addr_ff;
    nxt_resValid = resValid_ff;
    nxt_res = res_ff;
    if (anyXfer && ctrl0_ff[cnm_pkg::CTRL0_ACC_CLR_BIT]) begin
      nxt_acc = take ? freqWord : '0;
    end else if (take) begin
      nxt_acc = acc_ff + freqWord;
    end
    if (pipeMove) begin
      nxt_s1Valid = !enSyncN;
      nxt_s1Sample = sampleSync;
      nxt_s1Addr = {phaseTop, acc_ff[21:14]};
      nxt_resValid = s1Valid_ff;
      // I from cosine, Q from sine
      nxt_res.i = roundMix($signed(s1Sample_ff) * sinAmp(s1Addr_ff + 18'h10000));
      nxt_res.q = roundMix($signed(s1Sample_ff) * sinAmp(s1Addr_ff));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_ff <= '0;
      s1Valid_ff <= 1'b0;
      s1Sample_ff <= '0;
      s1Addr_ff <= '0;
      resValid_ff <= 1'b0;
      res_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
      s1Valid_ff <= nxt_s1Valid;
      s1Sample_ff <= nxt_s1Sample;
      s1Addr_ff <= nxt_s1Addr;
      resValid_ff <= nxt_resValid;
      res_ff <= nxt_res;
    end
  end

  // ========================================================================
  // two-entry output buffer: head is the output register, tail the spare
  always_comb begin
    nxt_outValid = outValid;
    nxt_outIq = outIq;
    nxt_tailValid = tailValid_ff;
    nxt_tail = tail_ff;
    if (outValid && outReady) begin
      if (tailValid_ff) begin
        nxt_outIq = tail_ff;
        nxt_tailValid = 1'b0;
      end else begin
        nxt_outValid = resValid_ff;
        nxt_outIq = res_ff;
      end
    end else if (resValid_ff && !tailValid_ff) begin
      if (outValid) begin
        nxt_tail = res_ff;
        nxt_tailValid = 1'b1;
      end else begin
        nxt_outIq = res_ff;
        nxt_outValid = 1'b1;
      end
    end
    // ready mirrors next cycle's pipeMove
    nxt_sampleReady = !(nxt_resValid && nxt_tailValid);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      outValid <= 1'b0;
      outIq <= '0;
      tailValid_ff <= 1'b0;
      tail_ff <= '0;
      sampleReady <= 1'b1;
    end else begin
      outValid <= nxt_outValid;
      outIq <= nxt_outIq;
      tailValid_ff <= nxt_tailValid;
      tail_ff <= nxt_tail;
      sampleReady <= nxt_sampleReady;
    end
  end

  // ========================================================================
  // checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_acc_hold: assert property (enSyncN && !anyXfer |=> $stable(acc_ff))
    else $error("accumulator moved without an enabled sample");
  a_acc_step: assert property (take && !anyXfer
    |=> acc_ff == $past(acc_ff) + $past(freqWord))
    else $error("accumulator step differs from the frequency word");
  a_offset_zero: assert property (ctrl0_ff[cnm_pkg::CTRL0_OFS_ZERO_BIT]
    |-> freqWord == freqAct_ff)
    else $error("serial offset leaked into the frequency word");
  a_cpu_xfer: assert property (wrFreqXfer |=> freqAct_ff == $past(freqHold_ff))
    else $error("frequency strobe did not copy the holding word");
  a_sync_xfer: assert property (syncEdge && ctrl1_ff[cnm_pkg::CTRL1_SYNC_EN_BIT]
    |=> freqAct_ff == $past(freqHold_ff) && phaseAct_ff == $past(phaseHold_ff))
    else $error("sync did not copy both holding words");
  a_clear_xfer: assert property (anyXfer && ctrl0_ff[cnm_pkg::CTRL0_ACC_CLR_BIT] && !take
    |=> acc_ff == 32'h0000_0000)
    else $error("accumulator not cleared on transfer");
  a_phase_add: assert property (pipeMove
    |=> s1Addr_ff[17:8] == $past(acc_ff[31:22]) + $past(phaseAct_ff))
    else $error("phase offset not added to the top bits");
  a_buf_order: assert property (tailValid_ff |-> outValid ##1 (outValid || tailValid_ff))
    else $error("buffer tail holds data while head is empty");

endmodule

/* tb/cnm_offset_sender.sv */
// serial offset word sender standing in for the external tracking logic
`timescale 1ns/1ps
module cnm_offset_sender (
  input wire logic clk,
  output logic serData,
  output logic wordStrobe
);
  // ==========================================================================
  // queued words, low bits of each entry are sent
  logic [31:0] wordQ[$];
  int widthQ[$];
  logic [31:0] cur;
  int left = 0;
  logic go;
  initial begin
    serData = 1'b0;
    wordStrobe = 1'b0;
  end
  // ==========================================================================
  // decide at the edge, drive just after it so queue pushes never race
  always @(posedge clk) begin
    go = (left <= 1) && (wordQ.size() > 0);
    #1;
    if (left > 0) begin
      serData = cur[31];
      cur = cur << 1;
      left = left - 1;
    end else begin
      serData = ~serData; // idle line keeps moving, never looks held
    end
    // one-clock strobe, may ride on the last data bit
    wordStrobe = go;
    if (go) begin
      left = widthQ.pop_front();
      cur = wordQ.pop_front() << (32 - left);
    end
  end
endmodule

/* tb/tb.sv */
// self-checking bench for the carrier oscillator and mixer
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic rst_n, cpuWrStrobe, frontSync, sampleEnableN, outReady;
  logic [4:0] cpuAddr;
  logic [31:0] cpuWrData;
  logic [31:0] cpuRdData;
  logic [cnm_pkg::SAMPLE_W-1:0] sampleIn;
  logic cSer, cStb, rSer, rStb, sampleReady, outValid, rLoad;
  cnm_pkg::cnm_iq_t outIq;
  logic [31:0] rHold;
  cnm_pkg::cnm_iq_t iqQ[$];
  logic [31:0] ldQ[$];
  int errors = 0;
  int samples_checked = 0;
  int cosT[4] = '{1, 0, -1, 0};
  int sinT[4] = '{0, 1, 0, -1};

  always #4 sys_clk = ~sys_clk;

  cnm_top dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .cpuWrStrobe(cpuWrStrobe), .cpuAddr(cpuAddr),
    .cpuWrData(cpuWrData), .cpuRdData(cpuRdData), .input_sample_enable_n(sampleEnableN),
    .sampleIn(sampleIn), .front_end_sync_in(frontSync), .carrier_offset_serial_data(cSer),
    .carrier_offset_word_strobe(cStb), .resampler_offset_serial_data(rSer),
    .resampler_offset_word_strobe(rStb), .sampleReady(sampleReady), .outValid(outValid),
    .outIq(outIq), .outReady(outReady), .resamplerOffsetHold(rHold),
    .resamplerOffsetLoad(rLoad)
  );
  cnm_offset_sender csnd (.clk(sys_clk), .serData(cSer), .wordStrobe(cStb));
  cnm_offset_sender rsnd (.clk(sys_clk), .serData(rSer), .wordStrobe(rStb));

  // ==========================================================================
  // capture of handed-over results and resampler loads
  always @(posedge sys_clk) begin
    if (outValid === 1'b1 && outReady === 1'b1) begin
      iqQ.push_back(outIq);
    end
    if (rLoad === 1'b1) begin
      ldQ.push_back(rHold);
    end
  end

  // ==========================================================================
  // expected values and compares
  function automatic logic [14:0] amp(input int s);
    int m;
    m = (s < 0) ? -s : s;
    m = (m * 131071 + 32768) >>> 16; // halves go away from zero
    return (s < 0) ? 15'(-m) : 15'(m);
  endfunction

  function automatic cnm_pkg::cnm_iq_t mk(input logic [14:0] i, input logic [14:0] q);
    mk.i = i;
    mk.q = q;
  endfunction

  task automatic check32(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic checkIq(input string n, input cnm_pkg::cnm_iq_t e, input cnm_pkg::cnm_iq_t g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // ==========================================================================
  // drivers, all entered one step after a rising edge
  task automatic cpuWrite(input logic [4:0] a, input logic [31:0] d);
    cpuAddr = a;
    cpuWrData = d;
    cpuWrStrobe = 1'b1;
    @(posedge sys_clk);
    #1;
    cpuWrStrobe = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic readChk(input logic [4:0] a, input logic [31:0] e);
    cpuAddr = a;
    repeat (2) @(posedge sys_clk);
    #1;
    check32("read back", e, cpuRdData);
  endtask

  task automatic sendSample(input int s, input int gap);
    sampleEnableN = 1'b0;
    sampleIn = 14'(s);
    @(posedge sys_clk);
    #1;
    sampleEnableN = 1'b1;
    sampleIn = ~sampleIn; // stale data must not pass for a sample
    repeat (gap) @(posedge sys_clk);
    #1;
  endtask

  task automatic syncPulse();
    frontSync = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    frontSync = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  // bounded wait: 0 for mixer results, 1 for resampler loads
  task automatic waitFill(input int which);
    int n;
    n = 0;
    while (((which == 0) ? iqQ.size() : ldQ.size()) == 0 && n < 300) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 300) begin
      errors++;
      $display("mismatch queue %0d expected an entry seen none", which);
    end
  endtask

  function automatic cnm_pkg::cnm_iq_t popIq();
    return (iqQ.size() > 0) ? iqQ.pop_front() : '0;
  endfunction

  // samples spaced by growing idle runs; dir above 0 is a +1 quarter turn, any other dir a -1 quarter turn
  task automatic spin(input int dir, input int n, output cnm_pkg::cnm_iq_t first);
    cnm_pkg::cnm_iq_t prev, got, e;
    for (int k = 0; k < n; k++) sendSample(1000, k + 1);
    waitFill(0);
    first = popIq();
    prev = first;
    for (int k = 1; k < n; k++) begin
      waitFill(0);
      got = popIq();
      e.i = (dir > 0) ? -prev.q : prev.q;
      e.q = (dir > 0) ? prev.i : -prev.i;
      checkIq("rotation", e, got);
      prev = got;
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end

  // ==========================================================================
  // test sequence
  initial begin
    cnm_pkg::cnm_iq_t f0, got;
    // idle levels driven from time zero, all inputs but the two serial data lines quiet in reset
    rst_n = 1'b0;
    cpuWrStrobe = 1'b0;
    cpuAddr = 5'h00;
    cpuWrData = 32'h0000_0000;
    sampleEnableN = 1'b1;
    sampleIn = 14'h0000;
    frontSync = 1'b0;
    outReady = 1'b1;
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    readChk(cnm_pkg::CW_CENTER, 32'h0000_0000);
    cpuWrite(5'h02, 32'hFFFF_FFFF);
    readChk(5'h02, 32'h0000_0000);
    cpuWrite(cnm_pkg::CW_CENTER, 32'h1234_5678);
    readChk(cnm_pkg::CW_CENTER, 32'h0000_0000);
    cpuWrite(cnm_pkg::CW_XFER_FREQ, 32'h0000_0000);
    readChk(cnm_pkg::CW_CENTER, 32'h1234_5678);
    cpuWrite(cnm_pkg::CW_PHASE, 32'hFFFF_FFFF);
    cpuWrite(cnm_pkg::CW_XFER_PHASE, 32'h0000_0000);
    readChk(cnm_pkg::CW_PHASE, 32'h0000_03FF);
    // sync ignored until enabled, then moves both words
    cpuWrite(cnm_pkg::CW_CTRL0, 32'h0000_0001);
    cpuWrite(cnm_pkg::CW_CENTER, 32'h0000_0000);
    cpuWrite(cnm_pkg::CW_PHASE, 32'h0000_0000);
    syncPulse();
    readChk(cnm_pkg::CW_CENTER, 32'h1234_5678);
    cpuWrite(cnm_pkg::CW_CTRL1, 32'h0010_0000);
    syncPulse();
    readChk(cnm_pkg::CW_CENTER, 32'h0000_0000);
    readChk(cnm_pkg::CW_PHASE, 32'h0000_0000);
    // quarter-turn phase offsets at rest, first pair held by a stall
    for (int k = 0; k < 4; k++) begin
      cpuWrite(cnm_pkg::CW_PHASE, 32'(k * 256));
      cpuWrite(cnm_pkg::CW_XFER_PHASE, 32'h0000_0000);
      outReady = (k != 0);
      sendSample(1000, 2);
      sendSample(-3, 2);
      if (k == 0) begin
        // a third sample fills the pipe behind the full buffer
        sendSample(1000, 2);
        repeat (8) @(posedge sys_clk);
        #1;
        check32("held valid", 32'h1, {31'h0, outValid});
        check32("early results", 32'h0, 32'(iqQ.size()));
        check32("ready low", 32'h0, {31'h0, sampleReady});
        outReady = 1'b1;
      end
      waitFill(0);
      checkIq("mix", mk(amp(1000 * cosT[k]), amp(1000 * sinT[k])), popIq());
      waitFill(0);
      checkIq("round", mk(amp(-3 * cosT[k]), amp(-3 * sinT[k])), popIq());
      if (k == 0) begin
        waitFill(0);
        checkIq("mix stalled", mk(amp(1000), amp(0)), popIq());
      end
    end
    // center minus a quarter plus serial half turn wraps to plus a quarter
    cpuWrite(cnm_pkg::CW_CENTER, 32'hC000_0000);
    cpuWrite(cnm_pkg::CW_XFER_FREQ, 32'h0000_0000);
    csnd.widthQ.push_back(8);
    csnd.wordQ.push_back(32'h0000_0080);
    repeat (16) @(posedge sys_clk);
    #1;
    spin(1, 4, f0);
    cpuWrite(cnm_pkg::CW_XFER_FREQ, 32'h0000_0000);
    spin(1, 1, got);
    checkIq("restart phase", f0, got);
    cpuWrite(cnm_pkg::CW_CTRL0, 32'h0000_0003);
    spin(-1, 4, got);
    // every resampler width, then two short words with no gap
    for (int w = 1; w <= 4; w++) begin
      cpuWrite(cnm_pkg::CW_RESAMP, 32'((w - 1) << 3));
      rsnd.widthQ.push_back(8 * w);
      rsnd.wordQ.push_back(32'h9ABC_DEF1);
      waitFill(1);
      check32("offset word", 32'h9ABC_DEF1 << (32 - 8 * w), ldQ.pop_front());
    end
    cpuWrite(cnm_pkg::CW_RESAMP, 32'h0000_0000);
    rsnd.widthQ.push_back(8);
    rsnd.wordQ.push_back(32'h0000_005A);
    rsnd.widthQ.push_back(8);
    rsnd.wordQ.push_back(32'h0000_00C3);
    waitFill(1);
    check32("first word", 32'h5A00_0000, ldQ.pop_front());
    waitFill(1);
    check32("second word", 32'hC300_0000, ldQ.pop_front());
    report_and_stop();
  end
endmodule
